// >>> sim/tb_scr_top.sv
// Self-checking bench for the seconds counter with alarm and periodic timeout.
// Assumes scr_pkg and scr_top compiled first; bench drives every port itself.
`default_nettype none
module tb_scr_top
	import scr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ********************************
	// Stimulus and observed signals
	// ********************************
	typedef struct packed {logic w; logic [15:0] a; logic [15:0] d; logic [15:0] e;} scr_row_t;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic osc_clk = 1'b0;
	logic osc_run = 1'b0;
	logic backup_st = 1'b0;
	logic sleep_st = 1'b0;
	logic off_st = 1'b0;
	logic osc_bk_en = 1'b1;
	logic [15:0] addr = 16'h0000;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] rdata;
	logic irq;
	logic wake;
	logic on_req;
	int errors = 0;
	int num_checks = 0;
	logic [15:0] val;
	logic [15:0] prev;
	int n;
	// Reads from reset, then writes with readback; trim stays locked here
	scr_row_t rows [15] = '{
		'{1'b0, SCR_OFS_FLAGS, 16'h0000, 16'h0000}, '{1'b0, SCR_OFS_MASK, 16'h0000, 16'h000c},
		'{1'b0, SCR_OFS_WTRK, 16'h0000, 16'h0000}, '{1'b0, SCR_OFS_SEC_HI, 16'h0000, 16'h0000},
		'{1'b0, SCR_OFS_SEC_LO, 16'h0000, 16'h0000}, '{1'b0, SCR_OFS_ALM_HI, 16'h0000, 16'h0000},
		'{1'b0, SCR_OFS_ALM_LO, 16'h0000, 16'h0000}, '{1'b0, SCR_OFS_CTRL, 16'h0000, 16'h0000},
		'{1'b0, SCR_OFS_TRIM, 16'h0000, 16'h0000}, '{1'b0, 16'h4030, 16'h0000, 16'h0000},
		'{1'b1, SCR_OFS_TRIM, 16'h0200, 16'h0000}, '{1'b1, 16'h4030, 16'h5555, 16'h0000},
		'{1'b1, SCR_OFS_ALM_LO, 16'h0009, 16'h0009}, '{1'b1, SCR_OFS_ALM_HI, 16'h0000, 16'h0000},
		'{1'b1, SCR_OFS_MASK, 16'h0008, 16'h0008}};

	// Hour window and second shortened so the run stays short
	scr_top #(.HOUR_SECONDS(4), .OSC_HZ(64)) u_scr_top (
		.ref_clk_in(ref_clk), .sys_rst_in(sys_rst), .osc_clk_in(osc_clk),
		.backup_state_in(backup_st), .sleep_state_in(sleep_st), .off_state_in(off_st),
		.backup_osc_enable_in(osc_bk_en), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .rtc_irq_out(irq),
		.wake_req_out(wake), .on_req_out(on_req));

	// System clock, 50 ns period
	always #25 ref_clk = ~ref_clk;
	// Oscillator pin, off-phase to the clock, about four clocks a period
	always
	begin
		#103.123;
		if (osc_run)
			osc_clk = ~osc_clk;
	end

	// ********************************
	// Shared tasks
	// ********************************
	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// An expired wait counts as a mismatch and ends the run
	task automatic expire();
		chk(16'h0000, 16'h0001);
		give_verdict();
	endtask : expire

	task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask : wr_reg

	// Data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [15:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		@(negedge ref_clk);
		d = rdata;
	endtask : rd_reg

	task automatic wait_idle();
		logic [15:0] c;
		for (int i = 0; i < 20; i++)
		begin
			rd_reg(SCR_OFS_CTRL, c);
			if (c[SCR_BIT_BUSY] === 1'b0)
				return;
		end
		expire();
	endtask : wait_idle

	// Returns just after a second boundary, with the new low count
	task automatic sync_sec(output logic [15:0] s);
		logic [15:0] p;
		rd_reg(SCR_OFS_SEC_LO, p);
		for (int i = 0; i < 2000; i++)
		begin
			rd_reg(SCR_OFS_SEC_LO, s);
			if (s !== p)
				return;
		end
		expire();
	endtask : sync_sec

	// ********************************
	// Main sequence
	// ********************************
	initial
	begin
		repeat (4) @(posedge ref_clk);
		sys_rst <= 1'b0;
		foreach (rows[i])
		begin
			if (rows[i].w)
			begin
				wr_reg(rows[i].a, rows[i].d);
				wait_idle();
			end
			rd_reg(rows[i].a, val);
			chk(val, rows[i].e);
		end
		$display("Register table test done");
		// Nine time writes with the oscillator still: the ninth is dropped
		prev = 16'h0000;
		for (int i = 1; i <= 9; i++)
		begin
			wr_reg(SCR_OFS_SEC_LO, 16'(i));
			if (i == 1)
			begin
				rd_reg(SCR_OFS_CTRL, val);
				chk(val, 16'hc000);
			end
			wait_idle();
			rd_reg(SCR_OFS_SEC_LO, val);
			chk(val, (i > SCR_UPD_LIMIT) ? 16'(SCR_UPD_LIMIT) : 16'(i));
			rd_reg(SCR_OFS_WTRK, val);
			chk({15'h0, (i > SCR_UPD_LIMIT) ? (val === prev)
				: (val !== prev && val !== prev + 16'h1)}, 16'h0001);
			prev = val;
		end
		$display("Update limit test done");
		wr_reg(SCR_OFS_KEY, SCR_UNLOCK_CODE);
		wr_reg(SCR_OFS_TRIM, 16'h0200);
		rd_reg(SCR_OFS_TRIM, val);
		chk(val, 16'h0200);
		$display("Trim unlock test done");
		// Alarm at count 9 while asleep
		@(posedge ref_clk);
		sleep_st <= 1'b1;
		wr_reg(SCR_OFS_CTRL, 16'h0400);
		osc_run = 1'b1;
		for (n = 0; n < 25000 && wake !== 1'b1; n++)
			@(negedge ref_clk);
		if (n == 25000)
			expire();
		chk({14'h0, wake, on_req}, 16'h0002);
		@(negedge ref_clk);
		chk({15'h0, irq}, 16'h0001);
		rd_reg(SCR_OFS_FLAGS, val);
		chk(val, 16'h0004);
		rd_reg(SCR_OFS_SEC_LO, val);
		chk(val, 16'h0009);
		wr_reg(SCR_OFS_FLAGS, 16'h0004);
		rd_reg(SCR_OFS_FLAGS, val);
		chk(val, 16'h0000);
		chk({15'h0, irq}, 16'h0000);
		$display("Alarm test done");
		// Alarm moved two seconds on, met again in the off state
		wr_reg(SCR_OFS_CTRL, 16'h0000);
		@(posedge ref_clk);
		sleep_st <= 1'b0;
		off_st <= 1'b1;
		wr_reg(SCR_OFS_ALM_LO, 16'h000b);
		wait_idle();
		wr_reg(SCR_OFS_CTRL, 16'h0400);
		for (n = 0; n < 25000 && on_req !== 1'b1; n++)
			@(negedge ref_clk);
		if (n == 25000)
			expire();
		chk({14'h0, wake, on_req}, 16'h0001);
		wr_reg(SCR_OFS_FLAGS, 16'h0004);
		@(posedge ref_clk);
		off_st <= 1'b0;
		$display("Off-state alarm test done");
		// Timeouts at both ends of the code range, masked, then opened
		wr_reg(SCR_OFS_MASK, 16'h000c);
		for (int k = 1; k <= 7; k += 6)
		begin
			sync_sec(prev);
			wr_reg(SCR_OFS_CTRL, 16'(k << SCR_BIT_PER_LO));
			for (n = 0; n < 20000; n++)
			begin
				rd_reg(SCR_OFS_FLAGS, val);
				if (val[SCR_BIT_PER_FLAG] === 1'b1)
					break;
			end
			if (n == 20000)
				expire();
			chk(val, 16'h0008);
			rd_reg(SCR_OFS_SEC_LO, val);
			chk(val - prev, 16'(1 << k));
			chk({15'h0, irq}, 16'h0000);
			if (k == 7)
			begin
				wr_reg(SCR_OFS_MASK, 16'h0000);
				rd_reg(SCR_OFS_MASK, val);
				chk(val, 16'h0000);
				chk({15'h0, irq}, 16'h0001);
			end
			// Disable first so the period counter restarts from zero
			wr_reg(SCR_OFS_CTRL, 16'h0000);
			wr_reg(SCR_OFS_FLAGS, 16'h0008);
			rd_reg(SCR_OFS_FLAGS, val);
			chk(val, 16'h0000);
		end
		$display("Periodic test done");
		// Backup without oscillator enable: count frozen, control reset
		@(posedge ref_clk);
		osc_bk_en <= 1'b0;
		backup_st <= 1'b1;
		rd_reg(SCR_OFS_SEC_LO, prev);
		wr_reg(SCR_OFS_SEC_LO, 16'h0abc);
		repeat (20000) @(posedge ref_clk);
		rd_reg(SCR_OFS_SEC_LO, val);
		chk(val, prev);
		rd_reg(SCR_OFS_MASK, val);
		chk(val, 16'h000c);
		rd_reg(SCR_OFS_CTRL, val);
		chk(val & 16'h8470, 16'h8000);
		// Backup with the oscillator kept: the count runs on
		@(posedge ref_clk);
		osc_bk_en <= 1'b1;
		repeat (1000) @(posedge ref_clk);
		rd_reg(SCR_OFS_SEC_LO, val);
		chk({15'h0, val != prev}, 16'h0001);
		$display("Backup test done");
		// Reset in mid-run: power-on values return
		@(posedge ref_clk);
		backup_st <= 1'b0;
		sys_rst <= 1'b1;
		repeat (4) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rd_reg(SCR_OFS_CTRL, val);
		chk(val, 16'h0000);
		rd_reg(SCR_OFS_WTRK, val);
		chk(val, 16'h0000);
		rd_reg(SCR_OFS_SEC_HI, val);
		chk(val, 16'h0000);
		rd_reg(SCR_OFS_MASK, val);
		chk(val, 16'h000c);
		$display("Mid-run reset test done");
		give_verdict();
	end
endmodule : tb_scr_top
`default_nettype wire

// >>> verilog/scr_pkg.sv
// Package for the seconds counter with alarm and periodic timeout.
// Assumes a single 20 MHz system clock and a 32.768 kHz oscillator pin.
`default_nettype none
package scr_pkg;
	// ********************************
	// Register offsets (word index)
	// ********************************
	localparam logic [15:0] SCR_OFS_FLAGS = 16'h4011;
	localparam logic [15:0] SCR_OFS_MASK = 16'h4019;
	localparam logic [15:0] SCR_OFS_WTRK = 16'h4020;
	localparam logic [15:0] SCR_OFS_SEC_HI = 16'h4021;
	localparam logic [15:0] SCR_OFS_SEC_LO = 16'h4022;
	localparam logic [15:0] SCR_OFS_ALM_HI = 16'h4023;
	localparam logic [15:0] SCR_OFS_ALM_LO = 16'h4024;
	localparam logic [15:0] SCR_OFS_CTRL = 16'h4025;
	localparam logic [15:0] SCR_OFS_TRIM = 16'h4026;
	localparam logic [15:0] SCR_OFS_KEY = 16'h4027;
	// ********************************
	// Field positions and reset values
	// ********************************
	localparam int SCR_BIT_VALID = 15;
	localparam int SCR_BIT_BUSY = 14;
	localparam int SCR_BIT_ALM_EN = 10;
	localparam int SCR_BIT_PER_HI = 6;
	localparam int SCR_BIT_PER_LO = 4;
	localparam int SCR_BIT_PER_FLAG = 3;
	localparam int SCR_BIT_ALM_FLAG = 2;
	localparam int SCR_BIT_OSC_BK = 0;
	localparam int SCR_TRIM_W = 10;
	localparam logic [15:0] SCR_RST_WORD = 16'h0000;
	localparam logic [1:0] SCR_RST_MASK = 2'h3;
	localparam logic [15:0] SCR_LFSR_SEED = 16'hace1;
	localparam logic [15:0] SCR_UNLOCK_CODE = 16'h9716;
	// ********************************
	// Timing
	// ********************************
	localparam int SCR_OSC_HZ = 32768;
	localparam int SCR_UPD_LIMIT = 8;
	localparam int SCR_HOUR_S = 3600;
	localparam int SCR_BUSY_CYC = 4;
	localparam logic [15:0] SCR_TRIM_FRAC = 16'h0040;
endpackage : scr_pkg
`default_nettype wire

// >>> verilog/scr_top.sv
// Seconds counter with alarm, periodic timeout and write tracking.
// Assumes osc_clk_in is a free 32.768 kHz pin, asynchronous to ref_clk_in.
//
// Summary of operation
// R1 - 32-bit seconds count from 32.768 kHz
// R2 - Count visible as high and low halves
// R3 - Valid bit cleared at reset, set on write
// R4 - Busy flag while update synchronises
// R5 - Tracker resets zero, random reload per write
// R6 - At most eight updates per hour
// R7 - Alarm registers and enable compare
// R8 - Alarm requests wake or on transition
// R9 - Host disables alarm before changing it
// R10 - Ten-bit signed trim corrects oscillator rate
// R11 - Trim writes need user key unlocked
// R12 - Periodic timeout two to 128 seconds
// R13 - Edge-set flags cleared by writing one
// R14 - Masked flags form one interrupt
// R15 - Counter runs in every power state except backup without oscillator enable
// R16 - Backup without oscillator enable freezes count
// R17 - Count halves start at zero
// R18 - Host saves tracker, detects foreign writes
// R19 - Backup entry resets alarm enable, period select, unlock and mask
// R20 - Each accepted half write counts once
// R21 - Mask zero passes, one masks
`default_nettype none
module scr_top
	import scr_pkg::*;
#(
	parameter int HOUR_SECONDS = SCR_HOUR_S,
	parameter int OSC_HZ = SCR_OSC_HZ
)(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	// Oscillator and power state
	input wire logic osc_clk_in,
	input wire logic backup_state_in,
	input wire logic sleep_state_in,
	input wire logic off_state_in,
	input wire logic backup_osc_enable_in,
	// Register port
	input wire logic [15:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [15:0] reg_rdata_out,
	// Events
	output logic rtc_irq_out,
	output logic wake_req_out,
	output logic on_req_out
);
	// Refuse windows the 12-bit second counter cannot hold
	if (HOUR_SECONDS < 1 || HOUR_SECONDS > 4096)
	begin : g_bad_hour
		$error("HOUR_SECONDS must be 1 to 4096");
	end
	// Limit stays positive at -8 Hz trim and fits the 23-bit phase
	if (OSC_HZ < 9 || OSC_HZ > 131064)
	begin : g_bad_osc
		$error("OSC_HZ must be 9 to 131064");
	end

	logic [1:0] osc_sync_reg;
	logic osc_prev_reg;
	logic osc_rise;
	logic [22:0] frac_reg;
	logic [22:0] frac_next;
	logic sec_tick;
	logic [31:0] sec_reg;
	logic [31:0] alarm_reg;
	logic valid_reg;
	logic alm_en_reg;
	logic [2:0] per_sel_reg;
	logic [9:0] trim_reg;
	logic unlocked_reg;
	logic [15:0] wtrk_reg;
	logic [15:0] lfsr_reg;
	logic [3:0] upd_cnt_reg;
	logic [11:0] hour_reg;
	logic [2:0] busy_reg;
	logic [6:0] per_cnt_reg;
	logic [1:0] flags_reg;
	logic [1:0] mask_reg;
	logic match_reg;
	logic soft_rst;
	logic wr_sec;
	logic sec_ok;
	logic per_hit;
	logic match_now;
	logic [23:0] frac_sum;
	logic [23:0] limit;

	// ********************************
	// Oscillator sampling and trim
	// ********************************
	// Backup entry clears control state, counter stays
	assign soft_rst = backup_state_in; // see R19
	assign osc_rise = osc_sync_reg[1] & ~osc_prev_reg;

	// Two flops before any logic looks at the pin
	always_ff @(posedge ref_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			osc_sync_reg <= 2'h0;
			osc_prev_reg <= 1'b0;
		end
		else
		begin
			osc_sync_reg <= {osc_sync_reg[0], osc_clk_in};
			osc_prev_reg <= osc_sync_reg[1];
		end
	end

	// Phase in 1/64-edge units: each edge adds 64, a second needs OSC_HZ plus trim/64
	// edges, so a fast crystal waits longer; a trim lowered mid-second ticks early
	assign limit = 24'(OSC_HZ * 64) + {{14{trim_reg[9]}}, trim_reg}; // see R10
	assign frac_sum = {1'b0, frac_reg} + 24'(SCR_TRIM_FRAC);
	always_comb
	begin
		frac_next = frac_sum[22:0];
		sec_tick = 1'b0;
		if (frac_sum >= limit)
		begin
			frac_next = 23'(frac_sum - limit);
			sec_tick = 1'b1; // see R1
		end
	end

	// Oscillator stops in backup unless enabled; count kept
	always_ff @(posedge ref_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			frac_reg <= 23'h0;
		else if (osc_rise && !(backup_state_in && !backup_osc_enable_in)) // see R15 see R16
			frac_reg <= frac_next;
	end

	assign sec_ok = osc_rise && sec_tick && !(backup_state_in && !backup_osc_enable_in);

	// ********************************
	// Seconds counter and update guard
	// ********************************
	// Writes are accepted only under the hourly budget
	assign wr_sec = reg_wr_in && !soft_rst && upd_cnt_reg < 4'(SCR_UPD_LIMIT)
		&& (reg_addr_in == SCR_OFS_SEC_HI || reg_addr_in == SCR_OFS_SEC_LO); // see R6 see R20

	always_ff @(posedge ref_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			sec_reg <= {SCR_RST_WORD, SCR_RST_WORD}; // see R17
		else if (wr_sec && reg_addr_in == SCR_OFS_SEC_HI)
			sec_reg <= {reg_wdata_in, sec_reg[15:0]}; // see R2
		else if (wr_sec)
			sec_reg <= {sec_reg[31:16], reg_wdata_in}; // see R2
		else if (sec_ok)
			sec_reg <= sec_reg + 32'h1; // see R1
	end

	// Hourly window of accepted updates, survives backup
	always_ff @(posedge ref_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			upd_cnt_reg <= 4'h0;
			hour_reg <= 12'h0;
		end
		else
		begin
			if (sec_ok && hour_reg == 12'(HOUR_SECONDS - 1))
			begin
				hour_reg <= 12'h0;
				upd_cnt_reg <= wr_sec ? 4'h1 : 4'h0; // see R6 see R20
			end
			else
			begin
				if (sec_ok)
					hour_reg <= hour_reg + 12'h1;
				if (wr_sec)
					upd_cnt_reg <= upd_cnt_reg + 4'h1; // see R20
			end
		end
	end

	// Free-running LFSR gives the random tracker value
	always_ff @(posedge ref_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			lfsr_reg <= SCR_LFSR_SEED;
			wtrk_reg <= SCR_RST_WORD;
		end
		else
		begin
			lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
			if (wr_sec)
				wtrk_reg <= lfsr_reg; // see R5
		end
	end

	// Busy covers the write plus a few settling cycles
	always_ff @(posedge ref_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			busy_reg <= 3'h0;
		else if (reg_wr_in && (reg_addr_in >= SCR_OFS_SEC_HI && reg_addr_in <= SCR_OFS_ALM_LO))
			busy_reg <= 3'(SCR_BUSY_CYC); // see R4
		else if (busy_reg != 3'h0)
			busy_reg <= busy_reg - 3'h1;
	end

	// ********************************
	// Control, alarm and trim registers
	// ********************************
	// Software-set state; alarm enable, period select and unlock cleared, mask set to all masked, on backup entry
	always_ff @(posedge ref_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			valid_reg <= 1'b0; // see R3
			alm_en_reg <= 1'b0;
			per_sel_reg <= 3'h0;
			alarm_reg <= 32'h0;
			trim_reg <= 10'h0;
			unlocked_reg <= 1'b0;
			mask_reg <= SCR_RST_MASK; // see R14
		end
		else if (soft_rst)
		begin
			alm_en_reg <= 1'b0; // see R19
			per_sel_reg <= 3'h0;
			unlocked_reg <= 1'b0;
			mask_reg <= SCR_RST_MASK;
		end
		else if (reg_wr_in)
		begin
			if (wr_sec)
				valid_reg <= 1'b1; // see R3
			case (reg_addr_in)
				SCR_OFS_ALM_HI: alarm_reg[31:16] <= reg_wdata_in; // see R7
				SCR_OFS_ALM_LO: alarm_reg[15:0] <= reg_wdata_in; // see R7
				SCR_OFS_CTRL:
				begin
					alm_en_reg <= reg_wdata_in[SCR_BIT_ALM_EN];
					per_sel_reg <= reg_wdata_in[SCR_BIT_PER_HI:SCR_BIT_PER_LO]; // see R12
				end
				SCR_OFS_TRIM:
				begin
					if (unlocked_reg)
						trim_reg <= reg_wdata_in[SCR_TRIM_W-1:0]; // see R11
				end
				SCR_OFS_KEY: unlocked_reg <= (reg_wdata_in == SCR_UNLOCK_CODE);
				SCR_OFS_MASK:
					mask_reg <= reg_wdata_in[SCR_BIT_PER_FLAG:SCR_BIT_ALM_FLAG]; // see R21
				default: ;
			endcase
		end
	end

	// ********************************
	// Events, flags and requests
	// ********************************
	assign match_now = alm_en_reg && (sec_reg == alarm_reg); // see R7
	assign per_hit = sec_ok && per_sel_reg != 3'h0
		&& per_cnt_reg == 7'((8'h1 << per_sel_reg) - 8'h1); // see R12

	// Period counter restarts when disabled
	always_ff @(posedge ref_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			per_cnt_reg <= 7'h0;
		else if (per_sel_reg == 3'h0 || per_hit)
			per_cnt_reg <= 7'h0;
		else if (sec_ok)
			per_cnt_reg <= per_cnt_reg + 7'h1;
	end

	// Set beats a simultaneous write-one clear
	always_ff @(posedge ref_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			match_reg <= 1'b0;
			flags_reg <= 2'h0;
		end
		else
		begin
			match_reg <= match_now;
			if (reg_wr_in && reg_addr_in == SCR_OFS_FLAGS)
				flags_reg <= flags_reg
					& ~reg_wdata_in[SCR_BIT_PER_FLAG:SCR_BIT_ALM_FLAG]; // see R13
			if (per_hit)
				flags_reg[1] <= 1'b1; // see R13
			if (match_now && !match_reg)
				flags_reg[0] <= 1'b1; // see R13
		end
	end

	// Outputs registered; alarm edge routed by power state
	always_ff @(posedge ref_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			rtc_irq_out <= 1'b0;
			wake_req_out <= 1'b0;
			on_req_out <= 1'b0;
		end
		else
		begin
			rtc_irq_out <= |(flags_reg & ~mask_reg); // see R14 see R21
			wake_req_out <= match_now && !match_reg && sleep_state_in; // see R8
			on_req_out <= match_now && !match_reg && off_state_in; // see R8
		end
	end

	// ********************************
	// Read port
	// ********************************
	// Data stand the cycle after the strobe; unmapped reads zero
	always_ff @(posedge ref_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			reg_rdata_out <= 16'h0;
		else if (reg_rd_in)
		begin
			case (reg_addr_in)
				SCR_OFS_FLAGS: reg_rdata_out <= {12'h0, flags_reg, 2'h0};
				SCR_OFS_MASK: reg_rdata_out <= {12'h0, mask_reg, 2'h0};
				SCR_OFS_WTRK: reg_rdata_out <= wtrk_reg; // see R5
				SCR_OFS_SEC_HI: reg_rdata_out <= sec_reg[31:16];
				SCR_OFS_SEC_LO: reg_rdata_out <= sec_reg[15:0];
				SCR_OFS_ALM_HI: reg_rdata_out <= alarm_reg[31:16];
				SCR_OFS_ALM_LO: reg_rdata_out <= alarm_reg[15:0];
				SCR_OFS_CTRL: reg_rdata_out <= {valid_reg, busy_reg != 3'h0, 3'h0,
					alm_en_reg, 3'h0, per_sel_reg, 4'h0}; // see R4
				SCR_OFS_TRIM: reg_rdata_out <= {6'h0, trim_reg};
				default: reg_rdata_out <= 16'h0;
			endcase
		end
		else
			reg_rdata_out <= 16'h0;
	end

	// ********************************
	// Assertions
	// ********************************
	AST_VALID_SET: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see R3
		wr_sec |=> valid_reg) else $error("valid not set after time write");
	AST_TRK_LOAD: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see R5
		wr_sec |=> wtrk_reg == $past(lfsr_reg)) else $error("tracker not reloaded");
	AST_LIMIT: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see R6
		upd_cnt_reg <= 4'(SCR_UPD_LIMIT)) else $error("update budget exceeded");
	AST_BUSY: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see R4
		wr_sec |=> busy_reg != 3'h0 [*3]) else $error("busy too short");
	AST_ALM_FLAG: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see R13
		(match_now && !match_reg) |=> flags_reg[0]) else $error("alarm flag not set");
	AST_IRQ: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see R14
		rtc_irq_out == $past(|(flags_reg & ~mask_reg))) else $error("irq mismatch");
	AST_WAKE: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see R8
		wake_req_out |-> $past(sleep_state_in)) else $error("wake outside sleep");
	AST_ON: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see R8
		on_req_out |-> $past(off_state_in)) else $error("on request outside off");
	AST_HOLD: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see R16
		(backup_state_in && !backup_osc_enable_in && !wr_sec) |=> $stable(sec_reg))
		else $error("count moved while frozen");
	AST_TRIM_LOCK: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in) // see R11
		!unlocked_reg |=> $stable(trim_reg)) else $error("trim changed while locked");
endmodule : scr_top
`default_nettype wire
